// ### verilog/hbi_pkg.sv
// Package with constants, types and the contract of the host bus and interrupt interface
// ==========================================================================
package hbi_pkg;
	localparam int ADDR_W = 9;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int N_TX_CH = 3;
	localparam int N_RX_CH = 8;
	localparam int N_TX_SRC = 6;
	localparam int N_RX_SRC = 9;
	localparam int N_REGS = 512;
	localparam int ACK_DELAY = 2;
	localparam logic [7:0] TX_VEC_BASE = 8'h40;
	localparam logic [7:0] RX_VEC_BASE = 8'h48;
	localparam logic [7:0] RX_PAR_VEC = 8'h50;
	localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

	typedef enum logic [1:0] {
		HBI_IDLE,
		HBI_WAIT,
		HBI_ACK
	} hbi_state_t;
endpackage

// ### verilog/hbi_bus_if.sv
// Interface joining the host end and the device end
interface hbi_bus_if;
	import hbi_pkg::*;
	logic [ADDR_W-1:0] reg_select_addr;
	logic [DATA_W-1:0] host_data_out;
	logic              host_data_oe;
	logic [DATA_W-1:0] dev_data_out;
	logic              dev_data_oe;
	logic              chip_select_n;
	logic              lower_byte_strobe_n;
	logic              upper_byte_strobe_n;
	logic              read_not_write;
	logic              transfer_ack_n_out;
	logic              transfer_ack_n_oe;
	logic              tx_int_request_n_oe;
	logic              rx_int_request_n_oe;
	logic              tx_int_acknowledge_n;
	logic              rx_int_acknowledge_n;
	logic              tx_chain_in_n;
	logic              rx_chain_in_n;
	logic              tx_chain_out_n;
	logic              rx_chain_out_n;
	logic [DATA_W-1:0] host_data_bus;
	logic              transfer_ack_n;
	logic              tx_int_request_n;
	logic              rx_int_request_n;

	// Wire resolution: pulled up where undriven
	assign host_data_bus    = dev_data_oe ? dev_data_out :
				  (host_data_oe ? host_data_out : {DATA_W{1'b1}});
	assign transfer_ack_n   = transfer_ack_n_oe ? transfer_ack_n_out : 1'b1;
	assign tx_int_request_n = tx_int_request_n_oe ? 1'b0 : 1'b1;
	assign rx_int_request_n = rx_int_request_n_oe ? 1'b0 : 1'b1;

	modport device (
		input  reg_select_addr, host_data_bus, chip_select_n, lower_byte_strobe_n,
		input  upper_byte_strobe_n, read_not_write, tx_int_acknowledge_n,
		input  rx_int_acknowledge_n, tx_chain_in_n, rx_chain_in_n,
		output dev_data_out, dev_data_oe, transfer_ack_n_out, transfer_ack_n_oe,
		output tx_int_request_n_oe, rx_int_request_n_oe, tx_chain_out_n, rx_chain_out_n
	);
	modport host (
		output reg_select_addr, host_data_out, host_data_oe, chip_select_n,
		output lower_byte_strobe_n, upper_byte_strobe_n, read_not_write,
		output tx_int_acknowledge_n, rx_int_acknowledge_n,
		input  host_data_bus, transfer_ack_n, tx_int_request_n, rx_int_request_n
	);
endinterface

// ### verilog/hbi_prio_enc.sv
// Priority encoder picking the first requesting source from a start index
module hbi_prio_enc
	import hbi_pkg::*;
#(
	parameter int N = 8
) (
	input  wire logic [N-1:0]         req,
	input  wire logic [$clog2(N)-1:0] start,
	output logic                      any,
	output logic [$clog2(N)-1:0]      idx
);
	localparam int IW = $clog2(N);

	logic [2*N-1:0] dbl;
	logic [2*N-1:0] rot;

	// ==========================================================================
	// Rotate so that start holds top priority
	assign dbl = {req, req};
	assign rot = dbl >> start;
	assign any = |req;

	always_comb begin
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (rot[i]) begin
				idx = IW'((i + int'(start)) % N);
			end
		end
	end
endmodule

// ### verilog/hbi_device.sv
// Device end: register access, transfer acknowledge and vectored interrupts
module hbi_device
	import hbi_pkg::*;
(
	input  wire logic                clk_sys,
	input  wire logic                resetn,
	hbi_bus_if.device                bus,
	input  wire logic [N_TX_CH-1:0]  tx_fifo_empty_evt,
	input  wire logic [N_TX_CH-1:0]  tx_end_evt,
	input  wire logic [N_RX_CH-1:0]  rx_valid_evt,
	input  wire logic                rx_parity_evt,
	input  wire logic [N_RX_CH*3-1:0] rx_prio_map,
	output logic [N_TX_SRC-1:0]      tx_pending,
	output logic [N_RX_SRC-1:0]      rx_pending,
	output logic [ADDR_W-1:0]        core_addr,
	output logic [DATA_W-1:0]        core_wdata,
	output logic                     core_write
);
	logic [DATA_W-1:0] regs [N_REGS];
	hbi_state_t        state;
	logic [1:0]        wait_cnt;
	logic              is_iack_tx;
	logic              is_iack_rx;
	logic              reg_req;
	logic              tx_claim;
	logic              rx_claim;
	logic              strobes_on;
	logic              tx_any;
	logic              rx_any;
	logic [2:0]        tx_ch;
	logic [1:0]        tx_idx;
	logic              vec_take;
	logic [3:0]        rx_idx;
	logic [2:0]        rx_ch_sel;
	logic [N_TX_CH-1:0] tx_ch_req;
	logic [7:0]        vector;
	logic [DATA_W-1:0] next_rdata;

	// ==========================================================================
	// Request decode
	assign strobes_on = !bus.lower_byte_strobe_n || !bus.upper_byte_strobe_n;
	assign reg_req    = !bus.chip_select_n && strobes_on;
	assign tx_claim   = !bus.tx_int_acknowledge_n && tx_any && !bus.tx_chain_in_n;
	assign rx_claim   = !bus.rx_int_acknowledge_n && rx_any && !bus.rx_chain_in_n;
	assign tx_any     = |tx_pending;
	assign rx_any     = |rx_pending;
	assign vec_take   = (state == HBI_WAIT) && (wait_cnt == 2'h0);

	// Chain outputs pass the grant on only when idle here
	assign bus.tx_chain_out_n = bus.tx_chain_in_n || tx_any;
	assign bus.rx_chain_out_n = bus.rx_chain_in_n || rx_any;
	assign bus.tx_int_request_n_oe = tx_any;
	assign bus.rx_int_request_n_oe = rx_any;

	// ==========================================================================
	// Pending interrupt sources, set wins over acknowledge clear
	genvar g;
	generate
		for (g = 0; g < N_TX_CH; g++) begin : g_tx_req
			assign tx_ch_req[g] = tx_pending[2*g] || tx_pending[2*g+1];
		end
		for (g = 0; g < N_TX_SRC; g++) begin : g_tx
			always_ff @(posedge clk_sys or negedge resetn) begin
				if (!resetn) begin
					tx_pending[g] <= 1'b0;
				end else if ((g % 2 == 0) ? tx_fifo_empty_evt[g/2] : tx_end_evt[g/2]) begin
					tx_pending[g] <= 1'b1;
				end else if (vec_take && is_iack_tx && tx_ch == 3'(g/2)) begin
					tx_pending[g] <= 1'b0;
				end
			end
		end
		for (g = 0; g < N_RX_SRC; g++) begin : g_rx
			always_ff @(posedge clk_sys or negedge resetn) begin
				if (!resetn) begin
					rx_pending[g] <= 1'b0;
				end else if ((g < N_RX_CH) ? rx_valid_evt[g % N_RX_CH] : rx_parity_evt) begin
					rx_pending[g] <= 1'b1;
				end else if (vec_take && is_iack_rx && rx_idx == 4'(g)) begin
					rx_pending[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ==========================================================================
	// Priority selection
	// Fixed order, channel 0 first
	hbi_prio_enc #(
		.N(N_TX_CH)
	) i_hbi_prio_enc (
		.req(tx_ch_req),
		.start(2'h0),
		.any(),
		.idx(tx_idx)
	);
	assign tx_ch = {1'b0, tx_idx};

	// Host map gives the channel number held by each priority rank
	always_comb begin
		rx_idx    = 4'(N_RX_CH);
		rx_ch_sel = 3'h0;
		for (int p = N_RX_CH - 1; p >= 0; p--) begin
			rx_ch_sel = rx_prio_map[3*p +: 3];
			if (rx_pending[rx_ch_sel]) begin
				rx_idx = {1'b0, rx_ch_sel};
			end
		end
		if (rx_idx == 4'(N_RX_CH) && !rx_pending[N_RX_CH]) begin
			rx_idx = 4'hf;
		end
	end

	always_comb begin
		if (is_iack_tx) begin
			vector = TX_VEC_BASE + 8'(tx_ch);
		end else if (rx_idx == 4'(N_RX_CH)) begin
			vector = RX_PAR_VEC;
		end else begin
			vector = RX_VEC_BASE + 8'(rx_idx);
		end
	end

	// ==========================================================================
	// Cycle control
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state      <= HBI_IDLE;
			wait_cnt   <= 2'h0;
			is_iack_tx <= 1'b0;
			is_iack_rx <= 1'b0;
		end else begin
			case (state)
				HBI_IDLE: begin
					is_iack_tx <= tx_claim;
					is_iack_rx <= rx_claim && !tx_claim;
					if (reg_req || tx_claim || rx_claim) begin
						state    <= HBI_WAIT;
						wait_cnt <= 2'(ACK_DELAY - 1);
					end
				end
				HBI_WAIT: begin
					if (wait_cnt == 2'h0) begin
						state <= HBI_ACK;
					end else begin
						wait_cnt <= wait_cnt - 2'h1;
					end
				end
				HBI_ACK: begin
					if (!strobes_on || (bus.chip_select_n && !is_iack_tx && !is_iack_rx)) begin
						state <= HBI_IDLE;
					end
				end
				default: state <= HBI_IDLE;
			endcase
		end
	end

	// ==========================================================================
	// Register file, byte lanes
	always_ff @(posedge clk_sys) begin
		if (state == HBI_WAIT && !is_iack_tx && !is_iack_rx && !bus.read_not_write) begin
			if (!bus.lower_byte_strobe_n) begin
				regs[bus.reg_select_addr][7:0] <= bus.host_data_bus[7:0];
			end
			if (!bus.upper_byte_strobe_n) begin
				regs[bus.reg_select_addr][15:8] <= bus.host_data_bus[15:8];
			end
		end
	end

	always_comb begin
		next_rdata = REG_RESET;
		if (!bus.lower_byte_strobe_n) begin
			next_rdata[7:0] = regs[bus.reg_select_addr][7:0];
		end
		if (!bus.upper_byte_strobe_n) begin
			next_rdata[15:8] = regs[bus.reg_select_addr][15:8];
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			bus.dev_data_out <= REG_RESET;
			bus.dev_data_oe  <= 1'b0;
			core_addr        <= '0;
			core_wdata       <= REG_RESET;
			core_write       <= 1'b0;
		end else begin
			core_write <= 1'b0;
			if (state == HBI_WAIT && wait_cnt == 2'h0) begin
				if (is_iack_tx || is_iack_rx) begin
					bus.dev_data_out <= {8'h00, vector};
					bus.dev_data_oe  <= 1'b1;
				end else if (bus.read_not_write) begin
					bus.dev_data_out <= next_rdata;
					bus.dev_data_oe  <= 1'b1;
				end else begin
					core_addr  <= bus.reg_select_addr;
					core_wdata <= bus.host_data_bus;
					core_write <= 1'b1;
				end
			end else if (state != HBI_ACK) begin
				bus.dev_data_oe <= 1'b0;
			end else if (!strobes_on) begin
				bus.dev_data_oe <= 1'b0;
			end
		end
	end

	assign bus.transfer_ack_n_out = !(state == HBI_ACK);
	assign bus.transfer_ack_n_oe  = (state == HBI_ACK);
endmodule

// ### verilog/hbi_host.sv
// Host end: runs register reads, writes and interrupt acknowledge cycles
module hbi_host
	import hbi_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              resetn,
	hbi_bus_if.host                bus,
	input  wire logic              req_valid,
	input  wire logic [1:0]        req_kind,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_wdata,
	input  wire logic [1:0]        req_bytes,
	output logic                   req_ready,
	output logic                   rsp_valid,
	output logic [DATA_W-1:0]      rsp_data,
	output logic                   tx_irq,
	output logic                   rx_irq
);
	hbi_state_t state;

	assign req_ready = (state == HBI_IDLE);
	assign tx_irq    = !bus.tx_int_request_n;
	assign rx_irq    = !bus.rx_int_request_n;

	// ==========================================================================
	// Bus cycle: kind 0 write, 1 read, 2 tx acknowledge, 3 rx acknowledge
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state                    <= HBI_IDLE;
			bus.reg_select_addr      <= '0;
			bus.host_data_out        <= '0;
			bus.host_data_oe         <= 1'b0;
			bus.chip_select_n        <= 1'b1;
			bus.lower_byte_strobe_n  <= 1'b1;
			bus.upper_byte_strobe_n  <= 1'b1;
			bus.read_not_write       <= 1'b1;
			bus.tx_int_acknowledge_n <= 1'b1;
			bus.rx_int_acknowledge_n <= 1'b1;
			rsp_valid                <= 1'b0;
			rsp_data                 <= '0;
		end else begin
			rsp_valid <= 1'b0;
			case (state)
				HBI_IDLE: begin
					if (req_valid) begin
						state                    <= HBI_WAIT;
						bus.reg_select_addr      <= req_addr;
						bus.host_data_out        <= req_wdata;
						bus.host_data_oe         <= (req_kind == 2'd0);
						bus.read_not_write       <= (req_kind != 2'd0);
						bus.chip_select_n        <= !(req_kind[1] == 1'b0);
						bus.tx_int_acknowledge_n <= !(req_kind == 2'd2);
						bus.rx_int_acknowledge_n <= !(req_kind == 2'd3);
						bus.lower_byte_strobe_n  <= !(req_bytes[0] || req_kind[1]);
						bus.upper_byte_strobe_n  <= !(req_bytes[1] && !req_kind[1]);
					end
				end
				HBI_WAIT: begin
					if (!bus.transfer_ack_n) begin
						state                    <= HBI_ACK;
						rsp_data                 <= bus.host_data_bus;
						rsp_valid                <= 1'b1;
						bus.chip_select_n        <= 1'b1;
						bus.lower_byte_strobe_n  <= 1'b1;
						bus.upper_byte_strobe_n  <= 1'b1;
						bus.tx_int_acknowledge_n <= 1'b1;
						bus.rx_int_acknowledge_n <= 1'b1;
						bus.host_data_oe         <= 1'b0;
					end
				end
				HBI_ACK: begin
					if (bus.transfer_ack_n) begin
						state <= HBI_IDLE;
					end
				end
				default: state <= HBI_IDLE;
			endcase
		end
	end
endmodule

// ### tb/hbi_props.sv
// Checker of the host bus and interrupt handshake seen on the interface
module hbi_props
	import hbi_pkg::*;
(
	input wire logic              clk_sys,
	input wire logic              resetn,
	input wire logic              chip_select_n,
	input wire logic              lower_byte_strobe_n,
	input wire logic              upper_byte_strobe_n,
	input wire logic              read_not_write,
	input wire logic              tx_int_acknowledge_n,
	input wire logic              rx_int_acknowledge_n,
	input wire logic              tx_chain_in_n,
	input wire logic              tx_chain_out_n,
	input wire logic              tx_int_request_n_oe,
	input wire logic              dev_data_oe,
	input wire logic              transfer_ack_n,
	input wire logic [DATA_W-1:0] host_data_bus
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	// ==========================================================
	// Steps of a bus cycle
	sequence s_reg_take;
		$fell(chip_select_n) && !(lower_byte_strobe_n && upper_byte_strobe_n);
	endsequence
	sequence s_all_idle;
		chip_select_n && lower_byte_strobe_n && upper_byte_strobe_n
			&& tx_int_acknowledge_n && rx_int_acknowledge_n;
	endsequence
	property p_rd_ack;
		s_reg_take ##0 read_not_write |-> ##3 !transfer_ack_n && dev_data_oe;
	endproperty
	property p_wr_ack;
		s_reg_take ##0 !read_not_write |-> ##3 !transfer_ack_n && !dev_data_oe;
	endproperty
	property p_ack_cause;
		$fell(transfer_ack_n) |-> $past(chip_select_n, 3) == 1'b0
			|| $past(tx_int_acknowledge_n, 3) == 1'b0
			|| $past(rx_int_acknowledge_n, 3) == 1'b0;
	endproperty
	property p_tx_iack;
		$fell(tx_int_acknowledge_n) && tx_int_request_n_oe && !tx_chain_in_n
			|-> ##3 !transfer_ack_n && dev_data_oe;
	endproperty
	property p_vec_lane;
		!transfer_ack_n && !(tx_int_acknowledge_n && rx_int_acknowledge_n)
			|-> host_data_bus[15:8] == 8'h00;
	endproperty
	property p_bus_dir;
		dev_data_oe && !chip_select_n |-> read_not_write;
	endproperty
	property p_ack_stand;
		!transfer_ack_n && !chip_select_n |=> !transfer_ack_n;
	endproperty
	property p_release;
		s_all_idle ##0 !transfer_ack_n |=> transfer_ack_n && !dev_data_oe;
	endproperty
	property p_chain;
		tx_chain_out_n == (tx_chain_in_n || tx_int_request_n_oe);
	endproperty
	// ==========================================================
	// Assertions
	a_rd_ack: assert property (p_rd_ack)
		else $error("read not acknowledged with data");
	a_wr_ack: assert property (p_wr_ack)
		else $error("write not acknowledged");
	a_ack_cause: assert property (p_ack_cause)
		else $error("acknowledge without select");
	a_tx_iack: assert property (p_tx_iack)
		else $error("transmit acknowledge cycle not answered");
	a_vec_lane: assert property (p_vec_lane)
		else $error("upper lanes not zero in vector");
	a_bus_dir: assert property (p_bus_dir)
		else $error("bus driven during write");
	a_ack_stand: assert property (p_ack_stand)
		else $error("acknowledge dropped early");
	a_release: assert property (p_release)
		else $error("acknowledge not released");
	a_chain: assert property (p_chain)
		else $error("chain output wrong");
endmodule

// ### tb/tb_top.sv
// Testbench running host accesses and interrupt acknowledges against the device
module tb_top
	import hbi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 clk_sys, resetn, req_valid, req_ready, rsp_valid;
	logic                 tx_irq, rx_irq, rx_parity_evt, tx_chain_in_n, rx_chain_in_n;
	logic [1:0]           req_kind, req_bytes;
	logic [ADDR_W-1:0]    req_addr;
	logic [DATA_W-1:0]    req_wdata, rsp_data, q;
	logic [N_TX_CH-1:0]   tx_fifo_empty_evt, tx_end_evt;
	logic [N_RX_CH-1:0]   rx_valid_evt;
	logic [N_RX_CH*3-1:0] rx_prio_map;
	logic [N_TX_SRC-1:0]  tx_pending;
	logic [N_RX_SRC-1:0]  rx_pending;
	int                   n_errors, compares;
	logic [ADDR_W-1:0]    core_addr;
	logic [DATA_W-1:0]    core_wdata;
	logic                 core_write;
	int                   n_core_wr = 0;

	hbi_bus_if i_hbi_bus_if ();
	assign i_hbi_bus_if.tx_chain_in_n = tx_chain_in_n;
	assign i_hbi_bus_if.rx_chain_in_n = rx_chain_in_n;
	hbi_device i_hbi_device (.clk_sys(clk_sys), .resetn(resetn), .bus(i_hbi_bus_if.device),
		.tx_fifo_empty_evt(tx_fifo_empty_evt), .tx_end_evt(tx_end_evt),
		.rx_valid_evt(rx_valid_evt), .rx_parity_evt(rx_parity_evt), .rx_prio_map(rx_prio_map),
		.tx_pending(tx_pending), .rx_pending(rx_pending), .core_addr(core_addr),
		.core_wdata(core_wdata), .core_write(core_write));
	hbi_host i_hbi_host (.clk_sys(clk_sys), .resetn(resetn), .bus(i_hbi_bus_if.host),
		.req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_bytes(req_bytes), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .tx_irq(tx_irq), .rx_irq(rx_irq));
	hbi_props i_hbi_props (.clk_sys(clk_sys), .resetn(resetn),
		.chip_select_n(i_hbi_bus_if.chip_select_n),
		.lower_byte_strobe_n(i_hbi_bus_if.lower_byte_strobe_n),
		.upper_byte_strobe_n(i_hbi_bus_if.upper_byte_strobe_n),
		.read_not_write(i_hbi_bus_if.read_not_write),
		.tx_int_acknowledge_n(i_hbi_bus_if.tx_int_acknowledge_n),
		.rx_int_acknowledge_n(i_hbi_bus_if.rx_int_acknowledge_n),
		.tx_chain_in_n(i_hbi_bus_if.tx_chain_in_n), .tx_chain_out_n(i_hbi_bus_if.tx_chain_out_n),
		.tx_int_request_n_oe(i_hbi_bus_if.tx_int_request_n_oe),
		.dev_data_oe(i_hbi_bus_if.dev_data_oe), .transfer_ack_n(i_hbi_bus_if.transfer_ack_n),
		.host_data_bus(i_hbi_bus_if.host_data_bus));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// Count write pulses handed to the core
	always @(posedge clk_sys) begin
		if (core_write === 1'b1) begin
			n_core_wr <= n_core_wr + 1;
		end
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		results();
	end
	// ==========================================================
	// Shared tasks
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("errors=%0d compares=%0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Kind 0 write, 1 read, 2 transmit acknowledge, 3 receive acknowledge
	task automatic access(input logic [1:0] k, input logic [ADDR_W-1:0] a,
			input logic [DATA_W-1:0] d, input logic [1:0] b);
		int n;
		n = 0;
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_kind <= k;
		req_addr <= a;
		req_wdata <= d;
		req_bytes <= b;
		@(negedge clk_sys);
		while (req_ready !== 1'b1 && n < 50) begin
			n++;
			@(negedge clk_sys);
		end
		@(posedge clk_sys);
		req_valid <= 1'b0;
		@(negedge clk_sys);
		while (rsp_valid !== 1'b1 && n < 50) begin
			n++;
			@(negedge clk_sys);
		end
		if (n >= 50) begin
			n_errors++;
			results();
		end
		q = rsp_data;
	endtask
	task automatic pulse(input logic [2:0] tf, input logic [2:0] te, input logic [7:0] rv,
			input logic rp);
		@(posedge clk_sys);
		tx_fifo_empty_evt <= tf;
		tx_end_evt <= te;
		rx_valid_evt <= rv;
		rx_parity_evt <= rp;
		@(posedge clk_sys);
		tx_fifo_empty_evt <= '0;
		tx_end_evt <= '0;
		rx_valid_evt <= '0;
		rx_parity_evt <= 1'b0;
		repeat (2) @(negedge clk_sys);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		n_errors = 0;
		compares = 0;
		req_valid = 1'b0;
		req_kind = 2'h0;
		req_addr = '0;
		req_wdata = '0;
		req_bytes = 2'h0;
		tx_fifo_empty_evt = '0;
		tx_end_evt = '0;
		rx_valid_evt = '0;
		rx_parity_evt = 1'b0;
		rx_prio_map = 24'h053977;
		tx_chain_in_n = 1'b0;
		rx_chain_in_n = 1'b0;
		resetn = 1'b0;
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		access(2'h0, 9'h1ff, 16'h1234, 2'h3);
		check(16'(core_addr), 16'h01ff);
		check(core_wdata, 16'h1234);
		access(2'h0, 9'h000, 16'habcd, 2'h3);
		access(2'h1, 9'h1ff, 16'h0000, 2'h3);
		check(q, 16'h1234);
		access(2'h1, 9'h000, 16'h0000, 2'h3);
		check(q, 16'habcd);
		access(2'h0, 9'h1ff, 16'h55aa, 2'h1);
		access(2'h0, 9'h1ff, 16'h77bb, 2'h2);
		access(2'h1, 9'h1ff, 16'h0000, 2'h3);
		check(q, 16'h77aa);
		check(16'(n_core_wr), 16'h0004);
		access(2'h1, 9'h1ff, 16'h0000, 2'h1);
		check(q, 16'h00aa);
		pulse(3'h7, 3'h4, 8'h00, 1'b0);
		check(16'(tx_pending), 16'h0035);
		check(16'(tx_irq), 16'h0001);
		@(posedge clk_sys);
		tx_chain_in_n <= 1'b1;
		@(negedge clk_sys);
		check(16'(i_hbi_bus_if.tx_chain_out_n), 16'h0001);
		@(posedge clk_sys);
		tx_chain_in_n <= 1'b0;
		for (int ch = 0; ch < N_TX_CH; ch++) begin
			access(2'h2, 9'h000, 16'h0000, 2'h3);
			check(q, {8'h00, TX_VEC_BASE + 8'(ch)});
		end
		repeat (2) @(negedge clk_sys);
		check(16'(tx_pending), 16'h0000);
		check(16'(tx_irq), 16'h0000);
		check(16'(i_hbi_bus_if.tx_chain_out_n), 16'h0000);
		pulse(3'h0, 3'h0, 8'h09, 1'b0);
		check(16'(rx_irq), 16'h0001);
		check(16'(i_hbi_bus_if.rx_chain_out_n), 16'h0001);
		access(2'h3, 9'h000, 16'h0000, 2'h3);
		check(q, {8'h00, RX_VEC_BASE + 8'h03});
		access(2'h3, 9'h000, 16'h0000, 2'h3);
		check(q, {8'h00, RX_VEC_BASE});
		pulse(3'h0, 3'h0, 8'h00, 1'b1);
		check(16'(rx_pending), 16'h0100);
		access(2'h3, 9'h000, 16'h0000, 2'h3);
		check(q, {8'h00, RX_PAR_VEC});
		repeat (2) @(negedge clk_sys);
		check(16'(rx_pending), 16'h0000);
		check(16'(i_hbi_bus_if.rx_chain_out_n), 16'h0000);
		results();
	end
endmodule
